// ### design/oesh_core.sv
// Registered datapath of the operand extend and saturate helpers.
// Assumes inputs come from core logic on sys_clk; no pins cross domains.
`timescale 1ns/1ps
`default_nettype none

module oesh_core
  import oesh_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        op_valid,
  input  wire oesh_op_t    op_sel,
  input  wire oesh_width_t operand_width_attr,
  input  wire oesh_width_t addr_width_attr,
  input  wire logic [31:0] src_a,
  input  wire logic [31:0] src_b,
  input  wire logic        src_is_byte,
  input  wire logic [4:0]  shift_count,
  output logic [31:0]      result,
  output logic             result_valid,
  input  wire logic [31:0] index_reg,
  input  wire logic        seg_override,
  input  wire logic [2:0]  seg_override_sel,
  output logic [31:0]      ea_offset,
  output logic [2:0]       ea_segment,
  input  wire logic        stack_push,
  input  wire logic        stack_pop,
  input  wire logic [31:0] stack_top_in,
  output logic [2:0]       stack_bytes,
  output logic [31:0]      pop_value,
  input  wire logic        fp_stack_drop,
  output logic [2:0]       fp_top,
  output logic [7:0]       fp_empty_tags,
  input  wire logic [31:0] bit_reg,
  input  wire logic [4:0]  bit_reg_offset,
  input  wire logic [31:0] bit_mem_base,
  input  wire logic [31:0] bit_mem_offset,
  output logic             bit_reg_value,
  output logic [31:0]      bit_mem_addr,
  output logic [2:0]       bit_mem_pos,
  input  wire logic        flags_write,
  input  wire logic [31:0] flags_affect,
  input  wire logic [31:0] flags_value,
  output logic [31:0]      status_flag_word,
  input  wire logic        fp_exc,
  output logic             fp_error_exception,
  output logic [7:0]       fp_error_vector
);

  localparam logic [2:0] DEFAULT_DATA_SEGMENT = 3'h3;
  localparam logic [2:0] BYTES_WORD  = 3'h2;
  localparam logic [2:0] BYTES_DWORD = 3'h4;

  typedef struct packed {
    logic [31:0] result;
    logic        result_valid;
    logic [31:0] ea_offset;
    logic [2:0]  ea_segment;
    logic [2:0]  stack_bytes;
    logic [31:0] pop_value;
    logic [2:0]  fp_top;
    logic [7:0]  fp_empty_tags;
    logic        bit_reg_value;
    logic [31:0] bit_mem_addr;
    logic [2:0]  bit_mem_pos;
    logic [31:0] flags;
    logic        fp_err;
  } oesh_state_t;

  oesh_state_t state;
  oesh_state_t next_state;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic [31:0] prod;
    logic [31:0] wide;
    logic [31:0] mask;
    logic signed [31:0] s16v;
    logic signed [31:0] s8v;
    next_state = state;
    prod = src_a[15:0] * src_b[15:0];
    mask = (operand_width_attr == OESH_W32) ? 32'hffff_ffff : 32'h0000_ffff;
    s16v = {{16{src_a[15]}}, src_a[15:0]};
    s8v  = {{24{src_a[7]}}, src_a[7:0]};
    wide = 32'h0000_0000;
    next_state.result_valid = op_valid;
    if (op_valid)
    begin
      case (op_sel)
        // A byte source widens; a word source at width 16 passes unchanged.
        OESH_OP_ZEXT:
          wide = src_is_byte ? {24'h00_0000, src_a[7:0]} : {16'h0000, src_a[15:0]};
        OESH_OP_SEXT:
          wide = src_is_byte ? s8v : s16v;
        OESH_OP_S16_S8:
          wide = oesh_clamp_s(s16v, $signed({{24{1'b1}}, S8_MIN}), {24'h0, S8_MAX});
        OESH_OP_S32_S16:
          wide = oesh_clamp_s(src_a, $signed({{16{1'b1}}, S16_MIN}), {16'h0, S16_MAX});
        OESH_OP_S16_U8:
          wide = oesh_clamp_u(s16v, {24'h0, U8_MAX});
        OESH_OP_RES_S8:
          wide = oesh_clamp_s(src_a, $signed({{24{1'b1}}, S8_MIN}), {24'h0, S8_MAX});
        OESH_OP_RES_S16:
          wide = oesh_clamp_s(src_a, $signed({{16{1'b1}}, S16_MIN}), {16'h0, S16_MAX});
        OESH_OP_RES_U8:
          wide = oesh_clamp_u(src_a, {24'h0, U8_MAX});
        OESH_OP_RES_U16:
          wide = oesh_clamp_u(src_a, {16'h0, U16_MAX});
        OESH_OP_MUL_LO:
          wide = {16'h0000, prod[15:0]};
        OESH_OP_MUL_HI:
          wide = {16'h0000, prod[31:16]};
        OESH_OP_SHL:
          wide = src_a << shift_count;
        OESH_OP_SHR:
          wide = (src_a & mask) >> shift_count;
        default:
          wide = 32'h0000_0000;
      endcase
      // Extensions and shifts follow the operand width; clamps keep their own width.
      if (op_sel == OESH_OP_ZEXT || op_sel == OESH_OP_SEXT || op_sel == OESH_OP_SHL)
        wide = wide & mask;
      else if (op_sel == OESH_OP_S16_S8 || op_sel == OESH_OP_RES_S8)
        wide = {24'h00_0000, wide[7:0]};
      else if (op_sel == OESH_OP_S32_S16 || op_sel == OESH_OP_RES_S16)
        wide = {16'h0000, wide[15:0]};
      next_state.result = wide;
    end
    next_state.ea_offset  = (addr_width_attr == OESH_W32) ? index_reg
                          : {16'h0000, index_reg[15:0]};
    next_state.ea_segment = seg_override ? seg_override_sel : DEFAULT_DATA_SEGMENT;
    next_state.stack_bytes = 3'h0;
    if (stack_push || stack_pop)
      next_state.stack_bytes = (operand_width_attr == OESH_W32) ? BYTES_DWORD : BYTES_WORD;
    if (stack_pop)
      next_state.pop_value = stack_top_in & mask;
    if (fp_stack_drop)
    begin
      next_state.fp_empty_tags[state.fp_top] = 1'b1;
      next_state.fp_top = state.fp_top + FP_PTR_STEP;
    end
    next_state.bit_reg_value = bit_reg[bit_reg_offset];
    // Arithmetic shift gives floor division; the low three bits are always non-negative.
    next_state.bit_mem_addr = bit_mem_base + 32'($signed(bit_mem_offset) >>> 3);
    next_state.bit_mem_pos  = bit_mem_offset[2:0];
    if (flags_write)
      next_state.flags = (state.flags & ~flags_affect) | (flags_value & flags_affect);
    next_state.fp_err = fp_exc;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      state <= '0;
    else
      state <= next_state;
  end

  assign result             = state.result;
  assign result_valid       = state.result_valid;
  assign ea_offset          = state.ea_offset;
  assign ea_segment         = state.ea_segment;
  assign stack_bytes        = state.stack_bytes;
  assign pop_value          = state.pop_value;
  assign fp_top             = state.fp_top;
  assign fp_empty_tags      = state.fp_empty_tags;
  assign bit_reg_value      = state.bit_reg_value;
  assign bit_mem_addr       = state.bit_mem_addr;
  assign bit_mem_pos        = state.bit_mem_pos;
  assign status_flag_word   = state.flags;
  assign fp_error_exception = state.fp_err;
  assign fp_error_vector    = FP_ERR_VECTOR;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_s16_s8_hi;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_S16_S8 && $signed(src_a[15:0]) > 16'sd127
      |=> result == 32'h0000_007f;
  endproperty
  a_s16_s8_hi: assert property (p_s16_s8_hi) else $error("s16 to s8 high clamp wrong");

  property p_s32_s16_lo;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_S32_S16 && $signed(src_a) < -32'sd32768
      |=> result == 32'h0000_8000;
  endproperty
  a_s32_s16_lo: assert property (p_s32_s16_lo) else $error("s32 to s16 low clamp wrong");

  property p_s16_u8_neg;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_S16_U8 && src_a[15] |=> result == 32'h0000_0000;
  endproperty
  a_s16_u8_neg: assert property (p_s16_u8_neg) else $error("s16 to u8 negative not zero");

  property p_u16_hi;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_RES_U16 && $signed(src_a) > 32'sd65535
      |=> result == 32'h0000_ffff;
  endproperty
  a_u16_hi: assert property (p_u16_hi) else $error("u16 high clamp wrong");

  property p_sext;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_SEXT && src_is_byte && operand_width_attr == OESH_W32
      |=> result == {{24{$past(src_a[7])}}, $past(src_a[7:0])};
  endproperty
  a_sext: assert property (p_sext) else $error("sign widening wrong");

  property p_mul_hi;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_MUL_HI
      |=> result[15:0] == 16'(({16'h0, $past(src_a[15:0])} * {16'h0, $past(src_b[15:0])}) >> 16);
  endproperty
  a_mul_hi: assert property (p_mul_hi) else $error("high half of product wrong");

  property p_fp_drop;
    @(posedge sys_clk) disable iff (!rst_n)
    fp_stack_drop |=> fp_top == 3'($past(fp_top) + 3'h1) && fp_empty_tags[$past(fp_top)];
  endproperty
  a_fp_drop: assert property (p_fp_drop) else $error("fp stack drop wrong");

  property p_flags_keep;
    @(posedge sys_clk) disable iff (!rst_n)
    !flags_write |=> $stable(status_flag_word);
  endproperty
  a_flags_keep: assert property (p_flags_keep) else $error("unlisted flags changed");

  property p_fp_err;
    @(posedge sys_clk) disable iff (!rst_n)
    fp_exc |=> fp_error_exception && fp_error_vector == 8'h10;
  endproperty
  a_fp_err: assert property (p_fp_err) else $error("fp error not raised on 16");

  property p_seg;
    @(posedge sys_clk) disable iff (!rst_n)
    !seg_override |=> ea_segment == 3'h3;
  endproperty
  a_seg: assert property (p_seg) else $error("default segment not used");

  // The pass-through and opposite-limit cases below catch a clamp that is one-sided.
  property p_s16_s8_lo;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_S16_S8 && $signed(src_a[15:0]) < -16'sd128
      |=> result == {24'h00_0000, S8_MIN};
  endproperty
  a_s16_s8_lo: assert property (p_s16_s8_lo) else $error("s16 to s8 low clamp wrong");

  property p_s16_s8_pass;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_S16_S8 && $signed(src_a[15:0]) >= -16'sd128
      && $signed(src_a[15:0]) <= 16'sd127
      |=> result == {24'h00_0000, $past(src_a[7:0])};
  endproperty
  a_s16_s8_pass: assert property (p_s16_s8_pass) else $error("s16 to s8 in range altered");

  property p_s32_s16_hi;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_S32_S16 && $signed(src_a) > 32'sd32767
      |=> result == {16'h0000, S16_MAX};
  endproperty
  a_s32_s16_hi: assert property (p_s32_s16_hi) else $error("s32 to s16 high clamp wrong");

  property p_s16_u8_hi;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_S16_U8 && !src_a[15] && src_a[14:0] > 15'h00ff
      |=> result == {24'h00_0000, U8_MAX};
  endproperty
  a_s16_u8_hi: assert property (p_s16_u8_hi) else $error("s16 to u8 high clamp wrong");

  property p_res_s8_hi;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_RES_S8 && $signed(src_a) > 32'sd127
      |=> result == {24'h00_0000, S8_MAX};
  endproperty
  a_res_s8_hi: assert property (p_res_s8_hi) else $error("result s8 high clamp wrong");

  property p_res_s8_lo;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_RES_S8 && $signed(src_a) < -32'sd128
      |=> result == {24'h00_0000, S8_MIN};
  endproperty
  a_res_s8_lo: assert property (p_res_s8_lo) else $error("result s8 low clamp wrong");

  property p_res_s16_hi;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_RES_S16 && $signed(src_a) > 32'sd32767
      |=> result == {16'h0000, S16_MAX};
  endproperty
  a_res_s16_hi: assert property (p_res_s16_hi) else $error("result s16 high clamp wrong");

  property p_res_s16_lo;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_RES_S16 && $signed(src_a) < -32'sd32768
      |=> result == {16'h0000, S16_MIN};
  endproperty
  a_res_s16_lo: assert property (p_res_s16_lo) else $error("result s16 low clamp wrong");

  property p_u8_hi;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_RES_U8 && $signed(src_a) > 32'sd255
      |=> result == {24'h00_0000, U8_MAX};
  endproperty
  a_u8_hi: assert property (p_u8_hi) else $error("result u8 high clamp wrong");

  property p_u_neg;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && (op_sel == OESH_OP_RES_U8 || op_sel == OESH_OP_RES_U16) && src_a[31]
      |=> result == 32'h0000_0000;
  endproperty
  a_u_neg: assert property (p_u_neg) else $error("unsigned clamp of negative not zero");

  property p_zext;
    @(posedge sys_clk) disable iff (!rst_n)
    op_valid && op_sel == OESH_OP_ZEXT && src_is_byte
      |=> result == {24'h00_0000, $past(src_a[7:0])};
  endproperty
  a_zext: assert property (p_zext) else $error("unsigned widening wrong");

  property p_stack32;
    @(posedge sys_clk) disable iff (!rst_n)
    (stack_push || stack_pop) && operand_width_attr == OESH_W32
      |=> stack_bytes == 3'h4;
  endproperty
  a_stack32: assert property (p_stack32) else $error("doubleword stack move wrong");

  property p_bit_pos;
    @(posedge sys_clk) disable iff (!rst_n)
    rst_n
      |=> bit_mem_pos == $past(bit_mem_offset[2:0]);
  endproperty
  a_bit_pos: assert property (p_bit_pos) else $error("memory bit position wrong");

  c_clamp: cover property (@(posedge sys_clk) op_valid && op_sel == OESH_OP_RES_S8);
  c_drop2: cover property (@(posedge sys_clk) fp_stack_drop ##1 fp_stack_drop);
  c_pop32: cover property (@(posedge sys_clk) stack_pop && operand_width_attr == OESH_W32);
  c_negbit: cover property (@(posedge sys_clk) bit_mem_offset[31]);

endmodule

`default_nettype wire

// ### design/oesh_pkg.sv
// Constants, types and helper functions for the operand extend and saturate helpers.
// Assumes a single core clock domain and a synchronous active-low core reset.
//
// What this block does
// - Operand width is either 16 or 32 bits; extensions, shifts and stack moves use it.
// - Index register read as 16-bit or 32-bit form per address width.
// - Bracketed index addresses memory in default data segment unless overridden.
// - Unsigned widening zero-fills upper bits to operand width; same width passes through.
// - Signed widening copies sign bit upward; same width passes through.
// - Signed 16 to signed 8 clamps to 80h and 7fh.
// - Signed 32 to signed 16 clamps to 8000h and 7fffh.
// - Signed 16 to unsigned 8 clamps negatives to 00h, above 255 to ffh.
// - Result saturated to signed byte clamps to 80h and 7fh.
// - Result saturated to signed word clamps to 8000h and 7fffh.
// - Unsigned result saturation: negatives to zero, byte ffh, word ffffh.
// - Word multiply forms full product, returns low or high word.
// - Push and pop move word or doubleword per operand width; pop returns top.
// - Floating stack drop tags head empty and advances stack pointer by one.
// - Bit positions count from the least significant bit upward.
// - Register bit-string offset selects one of bits 0 to 31.
// - Memory bit-string: byte at base plus floor(offset/8), bit offset mod 8.
// - Shift operators move destination by the count operand.
// - Flags: listed set/cleared, undefined free, unlisted keep old value.
// - Any floating-point exception raises the error exception on vector 16.

package oesh_pkg;

  localparam int W_DWORD = 32;
  localparam int W_WORD  = 16;
  localparam int W_BYTE  = 8;
  localparam int FP_DEPTH = 8;
  localparam int FP_PTR_W = 3;
  localparam int FLAG_W   = 32;

  localparam logic [7:0]  S8_MIN  = 8'h80;
  localparam logic [7:0]  S8_MAX  = 8'h7f;
  localparam logic [7:0]  U8_MAX  = 8'hff;
  localparam logic [7:0]  U8_MIN  = 8'h00;
  localparam logic [15:0] S16_MIN = 16'h8000;
  localparam logic [15:0] S16_MAX = 16'h7fff;
  localparam logic [15:0] U16_MAX = 16'hffff;
  localparam logic [7:0]  FP_ERR_VECTOR = 8'h10;
  localparam logic [2:0]  FP_PTR_STEP   = 3'h1;

  typedef enum logic {OESH_W16, OESH_W32} oesh_width_t;

  typedef enum logic [3:0] {
    OESH_OP_ZEXT, OESH_OP_SEXT, OESH_OP_S16_S8, OESH_OP_S32_S16, OESH_OP_S16_U8,
    OESH_OP_RES_S8, OESH_OP_RES_S16, OESH_OP_RES_U8, OESH_OP_RES_U16,
    OESH_OP_MUL_LO, OESH_OP_MUL_HI, OESH_OP_SHL, OESH_OP_SHR
  } oesh_op_t;

  // Signed clamp of a 32-bit two's complement value into a signed field.
  function automatic logic [31:0] oesh_clamp_s(input logic signed [31:0] v,
                                                input logic signed [31:0] lo,
                                                input logic signed [31:0] hi);
    if (v < lo)
      return lo;
    else if (v > hi)
      return hi;
    return v;
  endfunction

  // Unsigned clamp: negatives become zero, anything past hi becomes hi.
  function automatic logic [31:0] oesh_clamp_u(input logic signed [31:0] v,
                                                input logic signed [31:0] hi);
    if (v < 0)
      return 32'h0000_0000;
    else if (v > hi)
      return hi;
    return v;
  endfunction

endpackage

// ### dv/oesh_core_tb.sv
// Self-checking testbench for the operand extend and saturate helpers core.
// Assumes the core answers every request exactly one sys_clk cycle after it is taken.
`timescale 1ns/1ps
`default_nettype none

module oesh_core_tb
  import oesh_pkg::*;
;
  typedef struct packed {
    oesh_op_t    op;
    oesh_width_t wd;
    logic [31:0] a;
    logic [31:0] b;
    logic        byt;
    logic [4:0]  cnt;
    logic [31:0] exp;
  } oesh_row_t;

  // ----------------------------------------------------------------
  // Ordinary cases: one request per row, back to back.
  // ----------------------------------------------------------------
  localparam int NR = 26;
  localparam oesh_row_t ROWS [NR] = '{
    '{OESH_OP_ZEXT,    OESH_W32, 32'h0000_00f6, 32'h0, 1'b1, 5'h0, 32'h0000_00f6},
    '{OESH_OP_SEXT,    OESH_W32, 32'h0000_00f6, 32'h0, 1'b1, 5'h0, 32'hffff_fff6},
    '{OESH_OP_ZEXT,    OESH_W16, 32'h1234_abcd, 32'h0, 1'b0, 5'h0, 32'h0000_abcd},
    '{OESH_OP_SEXT,    OESH_W32, 32'h0000_8000, 32'h0, 1'b0, 5'h0, 32'hffff_8000},
    '{OESH_OP_S16_S8,  OESH_W32, 32'h0000_ff7f, 32'h0, 1'b0, 5'h0, 32'h0000_0080},
    '{OESH_OP_S16_S8,  OESH_W32, 32'h0000_ff80, 32'h0, 1'b0, 5'h0, 32'h0000_0080},
    '{OESH_OP_S16_S8,  OESH_W32, 32'h0000_0080, 32'h0, 1'b0, 5'h0, 32'h0000_007f},
    '{OESH_OP_S16_S8,  OESH_W32, 32'h0000_007f, 32'h0, 1'b0, 5'h0, 32'h0000_007f},
    '{OESH_OP_S32_S16, OESH_W32, 32'hffff_7fff, 32'h0, 1'b0, 5'h0, 32'h0000_8000},
    '{OESH_OP_S32_S16, OESH_W32, 32'h0000_8000, 32'h0, 1'b0, 5'h0, 32'h0000_7fff},
    '{OESH_OP_S32_S16, OESH_W32, 32'hffff_8000, 32'h0, 1'b0, 5'h0, 32'h0000_8000},
    '{OESH_OP_S16_U8,  OESH_W32, 32'h0000_ffff, 32'h0, 1'b0, 5'h0, 32'h0000_0000},
    '{OESH_OP_S16_U8,  OESH_W32, 32'h0000_0100, 32'h0, 1'b0, 5'h0, 32'h0000_00ff},
    '{OESH_OP_RES_S8,  OESH_W32, 32'h0000_0200, 32'h0, 1'b0, 5'h0, 32'h0000_007f},
    '{OESH_OP_RES_S8,  OESH_W32, 32'hffff_ff00, 32'h0, 1'b0, 5'h0, 32'h0000_0080},
    '{OESH_OP_RES_S16, OESH_W32, 32'hfffe_0000, 32'h0, 1'b0, 5'h0, 32'h0000_8000},
    '{OESH_OP_RES_S16, OESH_W32, 32'h0001_0000, 32'h0, 1'b0, 5'h0, 32'h0000_7fff},
    '{OESH_OP_RES_U8,  OESH_W32, 32'hffff_ffff, 32'h0, 1'b0, 5'h0, 32'h0000_0000},
    '{OESH_OP_RES_U8,  OESH_W32, 32'h0000_0100, 32'h0, 1'b0, 5'h0, 32'h0000_00ff},
    '{OESH_OP_RES_U16, OESH_W32, 32'h0001_0000, 32'h0, 1'b0, 5'h0, 32'h0000_ffff},
    '{OESH_OP_RES_U16, OESH_W32, 32'hffff_fff0, 32'h0, 1'b0, 5'h0, 32'h0000_0000},
    '{OESH_OP_MUL_LO,  OESH_W32, 32'h0000_1234, 32'h0000_0100, 1'b0, 5'h0, 32'h0000_3400},
    '{OESH_OP_MUL_HI,  OESH_W32, 32'h0000_1234, 32'h0000_0100, 1'b0, 5'h0, 32'h0000_0012},
    '{OESH_OP_SHL,     OESH_W16, 32'h0000_8001, 32'h0, 1'b0, 5'h01, 32'h0000_0002},
    '{OESH_OP_SHR,     OESH_W32, 32'h8000_0000, 32'h0, 1'b0, 5'h1f, 32'h0000_0001},
    '{OESH_OP_SHL,     OESH_W32, 32'h0000_0001, 32'h0, 1'b0, 5'h1f, 32'h8000_0000}
  };

  logic        sys_clk, rst_n, op_valid, src_is_byte, seg_override, stack_push, stack_pop;
  logic        fp_stack_drop, flags_write, fp_exc, result_valid, bit_reg_value;
  logic        fp_error_exception;
  oesh_op_t    op_sel;
  oesh_width_t operand_width_attr, addr_width_attr;
  logic [31:0] src_a, src_b, result, index_reg, ea_offset, stack_top_in, pop_value, bit_reg;
  logic [31:0] bit_mem_base, bit_mem_offset, bit_mem_addr, flags_affect, flags_value;
  logic [31:0] status_flag_word;
  logic [4:0]  shift_count, bit_reg_offset;
  logic [2:0]  seg_override_sel, ea_segment, stack_bytes, fp_top, bit_mem_pos;
  logic [7:0]  fp_empty_tags, fp_error_vector;
  int          error_cnt, n_tests;

  oesh_core DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .op_valid(op_valid), .op_sel(op_sel),
    .operand_width_attr(operand_width_attr), .addr_width_attr(addr_width_attr),
    .src_a(src_a), .src_b(src_b), .src_is_byte(src_is_byte), .shift_count(shift_count),
    .result(result), .result_valid(result_valid), .index_reg(index_reg),
    .seg_override(seg_override), .seg_override_sel(seg_override_sel),
    .ea_offset(ea_offset), .ea_segment(ea_segment), .stack_push(stack_push),
    .stack_pop(stack_pop), .stack_top_in(stack_top_in), .stack_bytes(stack_bytes),
    .pop_value(pop_value), .fp_stack_drop(fp_stack_drop), .fp_top(fp_top),
    .fp_empty_tags(fp_empty_tags), .bit_reg(bit_reg), .bit_reg_offset(bit_reg_offset),
    .bit_mem_base(bit_mem_base), .bit_mem_offset(bit_mem_offset),
    .bit_reg_value(bit_reg_value), .bit_mem_addr(bit_mem_addr), .bit_mem_pos(bit_mem_pos),
    .flags_write(flags_write), .flags_affect(flags_affect), .flags_value(flags_value),
    .status_flag_word(status_flag_word), .fp_exc(fp_exc),
    .fp_error_exception(fp_error_exception), .fp_error_vector(fp_error_vector)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Lets the capture edge pass, then samples once its updates have landed.
  task automatic settle();
    @(posedge sys_clk);
    #1;
  endtask

  // The run takes under 60 cycles; the limit of 5000 cycles leaves wide margin.
  initial
  begin
    #(40 * 5000);
    error_cnt++;
    stop_test();
  end

  initial
  begin
    error_cnt = 0; n_tests = 0;
    rst_n = 1'b0; op_valid = 1'b0; op_sel = OESH_OP_ZEXT; src_is_byte = 1'b0;
    operand_width_attr = OESH_W32; addr_width_attr = OESH_W32; src_a = '0; src_b = '0;
    shift_count = '0; index_reg = 32'h1234_5678; seg_override = 1'b0; seg_override_sel = '0;
    stack_push = 1'b0; stack_pop = 1'b0; stack_top_in = 32'hdead_beef; fp_stack_drop = 1'b0;
    bit_reg = 32'h0020_0000; bit_reg_offset = 5'd21; bit_mem_base = 32'h0000_1000;
    bit_mem_offset = 32'hffff_ffff; flags_write = 1'b0; flags_affect = '0; flags_value = '0;
    fp_exc = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    chk(result, 32'h0);
    chk({29'h0, fp_top}, 32'h0);
    chk(status_flag_word, 32'h0);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    op_valid <= 1'b1;
    for (int i = 0; i < NR; i++)
    begin
      op_sel <= ROWS[i].op; operand_width_attr <= ROWS[i].wd; src_a <= ROWS[i].a;
      src_b <= ROWS[i].b; src_is_byte <= ROWS[i].byt; shift_count <= ROWS[i].cnt;
      settle();
      chk(result, ROWS[i].exp);
      chk({31'h0, result_valid}, 32'h1);
    end
    // Result must stand while no request is made.
    op_valid <= 1'b0; src_a <= 32'h0000_0005;
    settle();
    settle();
    chk(result, 32'h8000_0000);
    chk({31'h0, result_valid}, 32'h0);
    chk(ea_offset, 32'h1234_5678);
    chk({29'h0, ea_segment}, 32'h3);
    chk({31'h0, bit_reg_value}, 32'h1);
    chk(bit_mem_addr, 32'h0000_0fff);
    chk({29'h0, bit_mem_pos}, 32'h7);
    chk({24'h0, fp_error_vector}, 32'h10);
    addr_width_attr <= OESH_W16; seg_override <= 1'b1; seg_override_sel <= 3'h5;
    bit_reg_offset <= 5'd20; bit_mem_offset <= 32'h0000_0013; fp_exc <= 1'b1;
    settle();
    chk(ea_offset, 32'h0000_5678);
    chk({29'h0, ea_segment}, 32'h5);
    chk({31'h0, bit_reg_value}, 32'h0);
    chk(bit_mem_addr, 32'h0000_1002);
    chk({29'h0, bit_mem_pos}, 32'h3);
    chk({31'h0, fp_error_exception}, 32'h1);
    fp_exc <= 1'b0; operand_width_attr <= OESH_W16; stack_push <= 1'b1;
    settle();
    chk({31'h0, fp_error_exception}, 32'h0);
    chk({29'h0, stack_bytes}, 32'h2);
    stack_push <= 1'b0; stack_pop <= 1'b1;
    settle();
    chk(pop_value, 32'h0000_beef);
    operand_width_attr <= OESH_W32;
    settle();
    chk(pop_value, 32'hdead_beef);
    chk({29'h0, stack_bytes}, 32'h4);
    stack_pop <= 1'b0;
    // Eight drops walk the pointer round once and tag every slot empty.
    for (int k = 0; k < 8; k++)
    begin
      @(posedge sys_clk);
      fp_stack_drop <= 1'b1;
      @(posedge sys_clk);
      fp_stack_drop <= 1'b0;
      #1;
      chk({29'h0, fp_top}, 32'(k + 1) & 32'h7);
      chk({24'h0, fp_empty_tags}, (32'h1 << (k + 1)) - 32'h1);
    end
    flags_write <= 1'b1; flags_affect <= 32'h0000_0001; flags_value <= 32'hffff_ffff;
    settle();
    flags_affect <= 32'h0000_0004; flags_value <= 32'h0000_0000;
    settle();
    chk(status_flag_word, 32'h0000_0001);
    flags_affect <= 32'h0000_0001;
    settle();
    chk(status_flag_word, 32'h0000_0000);
    flags_write <= 1'b0;
    stop_test();
  end
endmodule

`default_nettype wire
